//--- core/rtcc_mod_cnt.sv
// One modulo counter stage of the timekeeping chain.
// Assumes inc is a one-cycle enable; load takes priority over inc.
`timescale 1ns/100ps
module rtcc_mod_cnt
  import rtcc_pkg::*;
#(
  parameter int W   = 6,
  parameter int MOD = 60
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         inc,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] val,
  output logic              carry
);
  typedef struct packed {
    logic [W-1:0] val;
  } rtcc_cnt_t;

  localparam logic [W-1:0] LAST = W'(MOD - 1);

  rtcc_cnt_t s;
  rtcc_cnt_t next_s;

  assign val   = s.val;
  assign carry = inc && !load && (s.val == LAST);

  always_comb begin
    next_s = s;
    if (load) begin
      next_s.val = load_val;
    end else if (inc) begin
      next_s.val = (s.val == LAST) ? '0 : s.val + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // rtcc_mod_cnt

//--- core/rtcc_top.sv
// Real-time clock with two alarms, stopwatch, interrupt and wakeup.
// Assumes aclk is always on; crystal pin is asynchronous to it.
`timescale 1ns/100ps
module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int PRESC = PRESCALE,
  parameter int STW_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              rtc_crystal_in,
  output logic                   rtc_crystal_out,
  output logic                   irq,
  output logic                   wakeup
);
  localparam int PW = $clog2(PRESC);
  localparam logic [PW-1:0] PRESC_LAST = PW'(PRESC - 1);

  typedef struct packed {
    logic              xs1;
    logic              xs2;
    logic              xs3;
    logic              xout;
    logic [PW-1:0]     presc;
    logic              tick_d;
    logic              stw_en;
    logic [DATA_W-1:0] alarm;
    logic [STW_W-1:0]  stw;
    logic [EV_N-1:0]   sts;
    logic [EV_N-1:0]   ien;
    logic              irq;
    logic              wake;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
  } rtcc_state_t;

  rtcc_state_t s;
  rtcc_state_t next_s;

  logic              xedge;
  logic              tick;
  logic              wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] time_now;
  logic [DATA_W-1:0] time_wr;
  logic [DATA_W-1:0] stw_wr;
  logic              time_load;
  logic              stw_load;
  logic              sec_c;
  logic              min_c;
  logic              hr_c;
  logic [SEC_W-1:0]  sec;
  logic [MIN_W-1:0]  min;
  logic [HOUR_W-1:0] hour;
  logic [DAY_W-1:0]  day;
  logic [EV_N-1:0]   ev;
  logic [EV_N-1:0]   clr;

  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] nw,
    input logic [3:0]        strb
  );
    logic [DATA_W-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'b00};
    return (w == OFF_TIME) || (w == OFF_ALARM) || (w == OFF_CTRL) ||
           (w == OFF_STW) || (w == OFF_STS) || (w == OFF_CLR) ||
           (w == OFF_IEN);
  endfunction

  // The second and third synchroniser stages feed the edge detector
  assign xedge     = s.xs2 & ~s.xs3;
  assign tick      = xedge && (s.presc == PRESC_LAST);
  assign wr_fire   = s.aw_held && s.w_held && !s.bvalid;
  assign wr_addr   = {s.awaddr[ADDR_W-1:2], 2'b00};
  assign time_now  = {day, hour, min, sec};
  assign time_wr   = merge(time_now, s.wdata, s.wstrb);
  assign stw_wr    = merge(DATA_W'(s.stw), s.wdata, s.wstrb);
  // Whole time word reloads at once so the chain is never torn
  assign time_load = wr_fire && (wr_addr == OFF_TIME);
  assign stw_load  = wr_fire && (wr_addr == OFF_STW);

  rtcc_mod_cnt #(.W(SEC_W), .MOD(SEC_MOD)) u_sec (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (tick),
    .load     (time_load),
    .load_val (time_wr[SEC_LSB +: SEC_W]),
    .val      (sec),
    .carry    (sec_c)
  );
  rtcc_mod_cnt #(.W(MIN_W), .MOD(MIN_MOD)) u_min (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (sec_c),
    .load     (time_load),
    .load_val (time_wr[MIN_LSB +: MIN_W]),
    .val      (min),
    .carry    (min_c)
  );
  rtcc_mod_cnt #(.W(HOUR_W), .MOD(HOUR_MOD)) u_hour (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (min_c),
    .load     (time_load),
    .load_val (time_wr[HOUR_LSB +: HOUR_W]),
    .val      (hour),
    .carry    (hr_c)
  );
  rtcc_mod_cnt #(.W(DAY_W), .MOD(DAY_MOD)) u_day (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .inc      (hr_c),
    .load     (time_load),
    .load_val (time_wr[DAY_LSB +: DAY_W]),
    .val      (day),
    .carry    ()
  );

  always_comb begin
    next_s = s;
    // Crystal pin sampling and oscillator feedback drive
    next_s.xs1  = rtc_crystal_in;
    next_s.xs2  = s.xs1;
    next_s.xs3  = s.xs2;
    next_s.xout = ~s.xs2;
    if (xedge) begin
      next_s.presc = tick ? '0 : s.presc + 1'b1;
    end
    next_s.tick_d = tick;

    ev         = '0;
    ev[EV_SEC] = tick && !time_load;
    ev[EV_MIN] = sec_c;
    ev[EV_HR]  = min_c;
    ev[EV_DAY] = hr_c;
    ev[EV_STW] = tick && s.stw_en && !stw_load && (s.stw == '0);
    // Alarms compare the time settled one cycle after the tick
    ev[EV_AL1] = s.tick_d &&
                 (time_now[HMS_W-1:0] == s.alarm[HMS_W-1:0]);
    ev[EV_AL2] = s.tick_d && (time_now == s.alarm);

    clr = '0;
    if (wr_fire && (wr_addr == OFF_CLR) && s.wstrb[0]) begin
      clr = s.wdata[EV_N-1:0];
    end
    // A set in the same cycle as its clear wins
    next_s.sts = (s.sts & ~clr) | ev;

    // A load in the tick's cycle wins, so software sees its own value
    if (stw_load) begin
      next_s.stw = stw_wr[STW_W-1:0];
    end else if (tick && s.stw_en) begin
      next_s.stw = s.stw - 1'b1;
    end

    // Write channel: address and data taken in either order
    if (awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = wdata;
      next_s.wstrb  = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr == OFF_ALARM) begin
        next_s.alarm = merge(s.alarm, s.wdata, s.wstrb);
      end
      if (wr_addr == OFF_CTRL && s.wstrb[0]) begin
        next_s.stw_en = s.wdata[CTRL_STW_EN];
      end
      if (wr_addr == OFF_IEN && s.wstrb[0]) begin
        next_s.ien = s.wdata[EV_N-1:0];
      end
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // Read channel
    // Unmapped offsets answer with an error and read as zero
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case ({araddr[ADDR_W-1:2], 2'b00})
        OFF_TIME:  next_s.rdata = time_now;
        OFF_ALARM: next_s.rdata = s.alarm;
        OFF_CTRL:  next_s.rdata = DATA_W'(s.stw_en);
        OFF_STW:   next_s.rdata = DATA_W'(s.stw);
        OFF_STS:   next_s.rdata = DATA_W'(s.sts);
        OFF_IEN:   next_s.rdata = DATA_W'(s.ien);
        default:   next_s.rdata = '0;
      endcase
    end
    next_s.arready = !next_s.rvalid;

    // Level outputs from the enabled sticky bits
    // One enable set serves both, so a masked event never wakes the system
    next_s.irq  = |(next_s.sts & next_s.ien);
    next_s.wake = |(next_s.sts & next_s.ien);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign awready         = s.awready;
  assign wready          = s.wready;
  assign bvalid          = s.bvalid;
  assign bresp           = s.bresp;
  assign arready         = s.arready;
  assign rvalid          = s.rvalid;
  assign rresp           = s.rresp;
  assign rdata           = s.rdata;
  assign rtc_crystal_out = s.xout;
  assign irq             = s.irq;
  assign wakeup          = s.wake;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Checks are off in reset; the whole chain holds at zero there

  presc_wrap_a: assert property (
    tick |=> (s.presc == '0) && !$past(s.presc == '0) || PRESC == 1)
    else $error("Prescaler did not wrap on tick");
  sec_roll_a: assert property (
    tick && !time_load && sec == SEC_W'(SEC_MOD - 1)
    |=> sec == '0 && min == ($past(min) == MIN_W'(MIN_MOD - 1) ? '0
                              : $past(min) + 1'b1))
    else $error("Seconds rollover did not carry to minutes");
  day_wrap_a: assert property (
    hr_c && day == DAY_W'(DAY_MOD - 1) |=> day == '0)
    else $error("Day counter did not wrap to zero");
  min_event_a: assert property (
    sec_c |=> s.sts[EV_MIN])
    else $error("Minute rollover not flagged");
  alarm_daily_a: assert property (
    s.tick_d && time_now[HMS_W-1:0] == s.alarm[HMS_W-1:0]
    |=> s.sts[EV_AL1])
    else $error("Time of day alarm missed");
  alarm_day_a: assert property (
    s.tick_d && time_now != s.alarm && !s.sts[EV_AL2]
    && !(wr_fire && wr_addr == OFF_CLR) |=> !s.sts[EV_AL2])
    else $error("Day alarm fired without a match");
  alarm_irq_a: assert property (
    s.tick_d && time_now == s.alarm && s.ien[EV_AL2]
    && !(wr_fire && wr_addr == OFF_IEN) |=> irq)
    else $error("Enabled alarm did not raise interrupt");
  stw_count_a: assert property (
    tick && s.stw_en && !stw_load |=> s.stw == $past(s.stw) - 1'b1)
    else $error("Stopwatch did not decrement on tick");
  stw_under_a: assert property (
    tick && s.stw_en && !stw_load && s.stw == '0
    |=> s.sts[EV_STW] && s.stw == '1)
    else $error("Stopwatch underflow not flagged");
  wake_level_a: assert property (
    (irq == |(s.sts & s.ien)) && (wakeup == irq))
    else $error("Wakeup not raised for enabled event");
  set_wins_a: assert property (
    ev[EV_SEC] && clr[EV_SEC] |=> s.sts[EV_SEC])
    else $error("Event lost against same-cycle clear");
  keep_count_a: assert property (
    xedge && !tick |=> s.presc == $past(s.presc) + 1'b1)
    else $error("Prescaler stalled on crystal edge");
  sec_event_a: assert property (
    tick && !time_load |=> s.sts[EV_SEC])
    else $error("Second rollover not flagged");
  hr_event_a: assert property (
    min_c |=> s.sts[EV_HR])
    else $error("Hour rollover not flagged");
  day_event_a: assert property (
    hr_c |=> s.sts[EV_DAY])
    else $error("Day rollover not flagged");
  time_hold_a: assert property (
    !tick && !time_load |=> $stable(time_now))
    else $error("Time moved without a tick");
  stw_hold_a: assert property (
    !stw_load && !(tick && s.stw_en) |=> $stable(s.stw))
    else $error("Stopwatch moved without a tick");

  day_roll_c: cover property (hr_c ##1 s.sts[EV_DAY]);
  stw_fire_c: cover property (ev[EV_STW] ##[1:3] irq);
  alarm2_c:   cover property (ev[EV_AL2]);
  wr_rd_c:    cover property (wr_fire ##[1:8] (rvalid && rready));
endmodule // rtcc_top

//--- inc/rtcc_pkg.sv
// Constants for the real-time clock: register map, field layout, events.
// Assumes one 25 MHz always-on clock and an AXI4-Lite master with 32-bit data.
// Behaviour
// - Prescaler divides the 32.768 kHz crystal into a 1 Hz tick.
// - Seconds mod 60, minutes mod 60, hours mod 24, days 32768, chained.
// - Selectable interrupts on second, minute, hour and day rollover.
// - Enabled alarm interrupts when current time equals the alarm value.
// - First alarm compares hours, minutes, seconds only; fires daily.
// - Second alarm also compares day; fires once at that day and time.
// - Stopwatch loads a programmed value and decrements once per tick.
// - Enabled stopwatch raises an interrupt when it underflows past zero.
// - Any enabled clock event asserts the wakeup indication.
// - Counting continues from the crystal independent of the bus side.
package rtcc_pkg;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  // Register byte offsets
  localparam logic [7:0] OFF_TIME  = 8'h00;
  localparam logic [7:0] OFF_ALARM = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_STW   = 8'h0C;
  localparam logic [7:0] OFF_STS   = 8'h10;
  localparam logic [7:0] OFF_CLR   = 8'h14;
  localparam logic [7:0] OFF_IEN   = 8'h18;
  // Time word layout, shared by time and alarm registers
  localparam int SEC_LSB  = 0;
  localparam int SEC_W    = 6;
  localparam int MIN_LSB  = 6;
  localparam int MIN_W    = 6;
  localparam int HOUR_LSB = 12;
  localparam int HOUR_W   = 5;
  localparam int DAY_LSB  = 17;
  localparam int DAY_W    = 15;
  localparam int HMS_W    = 17;
  localparam int SEC_MOD  = 60;
  localparam int MIN_MOD  = 60;
  localparam int HOUR_MOD = 24;
  localparam int DAY_MOD  = 32768;
  // Crystal and tick rates
  localparam int XTAL_HZ  = 32768;
  localparam int TICK_HZ  = 1;
  localparam int PRESCALE = XTAL_HZ / TICK_HZ;
  // Control bits
  localparam int CTRL_STW_EN = 0;
  // Event bits of status, clear and enable registers
  localparam int EV_N   = 7;
  localparam int EV_SEC = 0;
  localparam int EV_MIN = 1;
  localparam int EV_HR  = 2;
  localparam int EV_DAY = 3;
  localparam int EV_STW = 4;
  localparam int EV_AL1 = 5;
  localparam int EV_AL2 = 6;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- sim/test_rtcc_top.sv
// Self-checking bench for the real-time clock, driven over its register bus.
// Assumes rtcc_pkg and the design sources are compiled before this file.
`timescale 1ns/100ps
module test_rtcc_top
  import rtcc_pkg::*;
;
  localparam int PR   = 4;            // Crystal rising edges per tick, kept short
  localparam int XH   = 10;           // Crystal half period in aclk cycles
  localparam int TICK = PR * 2 * XH;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              xtal, xout, irq, wakeup;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  int                err_total, compares, cyc, xc, t1, t2;
  logic [7:0]        offs [7] = '{OFF_TIME, OFF_ALARM, OFF_CTRL, OFF_STW,
                                  OFF_STS, OFF_CLR, OFF_IEN};

  rtcc_top #(.PRESC(PR), .STW_W(16)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .rtc_crystal_in(xtal), .rtc_crystal_out(xout), .irq(irq),
    .wakeup(wakeup)
  );

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Crystal is far slower than aclk, as the sampler needs; it toggles on aclk edges
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    xc  <= (xc == XH - 1) ? 0 : xc + 1;
    if (xc == XH - 1) xtal <= ~xtal;
    if (cyc == 20000) begin
      err_total++;
      $display("BAD timeout exp finished got hang");
      finish_test();
    end
  end

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Each task starts one edge later, so no strobe is driven twice a step
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bvalid", 32'h0000_0001, {31'h0, bvalid});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (arready && arvalid) arvalid <= 1'b0;
    end
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (rvalid !== 1'b1) chk("rvalid", 32'h0000_0001, {31'h0, rvalid});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    chk(nm, e, d);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
  endtask

  task automatic rdm(input string nm, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask

  // Returns the cycle at which the time word was first seen to move
  task automatic wait_tick(output int at);
    logic [31:0] t0;
    logic [31:0] t;
    int          n;
    rd(OFF_TIME, t0, r);
    for (n = 0; n < 200; n++) begin
      rd(OFF_TIME, t, r);
      if (t !== t0) break;
    end
    if (t === t0) chk("time moved", 32'h1, 32'h0);
    at = cyc;
  endtask

  function automatic logic [31:0] mk(int dy, int h, int m, int s);
    return (32'(dy) << DAY_LSB) | (32'(h) << HOUR_LSB) |
           (32'(m) << MIN_LSB) | 32'(s);
  endfunction

  task automatic sts_chk(input string nm, input logic [31:0] m,
                         input logic [31:0] e);
    repeat (3) @(posedge aclk);
    rdm(nm, OFF_STS, m, e);
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, xtal} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    {err_total, compares, cyc, xc} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (offs[i]) rdc("reset value", offs[i], 32'h0, RESP_OKAY);
    chk("irq idle", 32'h0, {31'h0, irq});
    rdc("unmapped read", 8'h1C, 32'h0, RESP_SLVERR);
    wr(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test reset_and_map done");

    wait_tick(t1);
    wait_tick(t2);
    chk("tick period", 32'h1, 32'((t2 - t1 >= TICK - 8) &&
        (t2 - t1 <= TICK + 8)));
    // Pin level settled for several cycles, so the drive shows its inverse
    repeat (2) begin
      do @(posedge aclk); while (xc != 6);
      chk("crystal drive", {31'h0, ~xtal}, {31'h0, xout});
    end
    $display("test tick_rate done");

    // Alarm parked on a time that never comes, so only rollovers show
    wr(OFF_ALARM, mk(9, 9, 9, 9), RESP_OKAY);
    wr(OFF_IEN, 32'h0000_007F, RESP_OKAY);
    wait_tick(t1);
    wr(OFF_TIME, mk(32767, 23, 59, 59), RESP_OKAY);
    wr(OFF_CLR, 32'h0000_007F, RESP_OKAY);
    wait_tick(t1);
    rdc("time wrap", OFF_TIME, 32'h0, RESP_OKAY);
    sts_chk("rollover events", 32'hFFFF_FFFF, 32'h0000_000F);
    chk("irq set", 32'h1, {31'h0, irq});
    chk("wakeup set", 32'h1, {31'h0, wakeup});
    wr(OFF_IEN, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("wakeup masked", 32'h0, {31'h0, wakeup});
    wr(OFF_IEN, 32'h1 << EV_DAY, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq day only", 32'h1, {31'h0, irq});
    wr(OFF_CLR, 32'h0000_007F, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc("clear reads zero", OFF_CLR, 32'h0, RESP_OKAY);
    $display("test rollover done");

    wr(OFF_IEN, 32'h1 << EV_AL1, RESP_OKAY);
    wait_tick(t1);
    wr(OFF_TIME, mk(3, 1, 2, 3), RESP_OKAY);
    wr(OFF_ALARM, mk(7, 1, 2, 5), RESP_OKAY);
    wr(OFF_CLR, 32'h0000_007F, RESP_OKAY);
    wait_tick(t1);
    wait_tick(t1);
    rdc("time count", OFF_TIME, mk(3, 1, 2, 5), RESP_OKAY);
    sts_chk("daily alarm", 32'h0000_0060, 32'h0000_0020);
    chk("alarm irq", 32'h1, {31'h0, irq});
    wr(OFF_IEN, 32'h1 << EV_AL2, RESP_OKAY);
    wr(OFF_ALARM, mk(3, 1, 2, 7), RESP_OKAY);
    wr(OFF_CLR, 32'h0000_007F, RESP_OKAY);
    wait_tick(t1);
    wait_tick(t1);
    sts_chk("day alarm", 32'h0000_0060, 32'h0000_0060);
    chk("day alarm irq", 32'h1, {31'h0, irq});
    // Only the low byte lane is written; the others keep the alarm
    wstrb <= 4'h1;
    wr(OFF_ALARM, 32'hFFFF_FFFF, RESP_OKAY);
    wstrb <= 4'hF;
    rdc("alarm byte write", OFF_ALARM, mk(3, 1, 2, 7) | 32'h0000_00FF,
        RESP_OKAY);
    $display("test alarms done");

    wr(OFF_IEN, 32'h1 << EV_STW, RESP_OKAY);
    wait_tick(t1);
    wr(OFF_STW, 32'h0000_0002, RESP_OKAY);
    wr(OFF_CTRL, 32'h1 << CTRL_STW_EN, RESP_OKAY);
    wr(OFF_CLR, 32'h0000_007F, RESP_OKAY);
    wait_tick(t1);
    wait_tick(t1);
    rdc("stopwatch at zero", OFF_STW, 32'h0, RESP_OKAY);
    sts_chk("no underflow yet", 32'h0000_0010, 32'h0);
    chk("stopwatch irq low", 32'h0, {31'h0, irq});
    wait_tick(t1);
    rdc("stopwatch wrap", OFF_STW, 32'h0000_FFFF, RESP_OKAY);
    sts_chk("underflow flag", 32'h0000_0010, 32'h0000_0010);
    chk("stopwatch irq", 32'h1, {31'h0, irq});
    chk("stopwatch wakeup", 32'h1, {31'h0, wakeup});
    wr(OFF_CTRL, 32'h0, RESP_OKAY);
    $display("test stopwatch done");
    finish_test();
  end
endmodule // test_rtcc_top
